// ===== rtl/hht_pkg.sv
// Package for the host handshake and trigger block: modes, straps, configuration bits and timing.
// Assumes a single 20 MHz clock shared by both ends.
package hht_pkg;
  // ==========================================================================
  // Terminal operating modes
  typedef enum logic [2:0] {
    HHT_MODE_RT,
    HHT_MODE_BC,
    HHT_MODE_EBC,
    HHT_MODE_WMON,
    HHT_MODE_MMON
  } hht_mode_t;

  // ==========================================================================
  // Host port strap values and memory/register select values
  localparam logic HHT_STRAP_BUFFERED = 1'b0;
  localparam logic HHT_STRAP_TRANSPARENT = 1'b1;
  localparam logic HHT_SEL_MEM = 1'b1;
  localparam logic HHT_SEL_REG = 1'b0;

  // ==========================================================================
  // Configuration bit positions and widths
  localparam int HHT_CFG_FLAG_BIT = 8;
  localparam int HHT_CFG_EXTSTART_BIT = 7;
  localparam int HHT_CFG_W = 16;
  localparam int HHT_DATA_W = 16;
  localparam int HHT_ADDR_W = 16;
  localparam logic [15:0] HHT_CFG_RESET = 16'h0000;

  // ==========================================================================
  // Internal access timing
  localparam int HHT_CLK_MHZ = 20;
  localparam int HHT_ACCESS_NS = 100;
  localparam int HHT_ACCESS_CYC = (HHT_ACCESS_NS * HHT_CLK_MHZ + 999) / 1000;
  localparam int HHT_CNT_W = 4;
endpackage

// ===== rtl/hht_if.sv
// Interface joining the host bus logic to the terminal's processor port.
// Assumes both ends run on the same clock; the testbench owns the clock.
`timescale 1ns/10ps
`default_nettype none
interface hht_if (input wire logic clk);
  import hht_pkg::*;
  logic host_strobe_n;
  logic host_rd;
  logic mem_reg_sel;
  logic [HHT_ADDR_W-1:0] addr;
  logic [HHT_DATA_W-1:0] wdata;
  logic [HHT_DATA_W-1:0] rdata;
  logic host_ready_n;
  logic io_enable_n_out;
  logic host_mode_strap;
  logic external_trigger_in;

  modport device (
    input host_strobe_n, host_rd, mem_reg_sel, addr, wdata, host_mode_strap,
    input external_trigger_in,
    output rdata, host_ready_n, io_enable_n_out
  );
  modport host (
    output host_strobe_n, host_rd, mem_reg_sel, addr, wdata,
    input rdata, host_ready_n, io_enable_n_out
  );
endinterface
`default_nettype wire

// ===== rtl/hht_device.sv
// Terminal end of the processor port: ready handshake, I/O enable, trigger
// and subsystem flag. Assumes host pins and trigger arrive asynchronously.
//
// Behaviour
// R1: RT status flag set while flag pin low.
// R2: Flag pin never alters stored flag bit.
// R3: Trigger rise starts BC frame when enabled.
// R4: Enhanced BC trigger wait resumes on rise.
// R5: Trigger rise starts word monitor when enabled.
// R6: Message monitor ignores the trigger.
// R7: Strap selects buffered or transparent host mode.
// R8: Nonzero-wait read: ready low once data valid.
// R9: Nonzero-wait write: ready low once data stored.
// R10: Host holds strobe low until ready.
// R11: Buffered zero-wait: ready high while idle.
// R12: Zero-wait ready low during access, high after.
// R13: I/O enable low during internal access.
// R14: Host uses I/O enable for buffers.
// R15: Host selects memory 1, register 0.
// R16: Trigger synchronised, one event per rise.
`timescale 1ns/10ps
`default_nettype none
module hht_device
  import hht_pkg::*;
#(
  parameter int ACCESS_CYC = HHT_ACCESS_CYC, // Internal access length in cycles
  parameter int MEM_WORDS = 16 // Modelled shared RAM words
) (
  input wire logic clk, // Clock
  input wire logic arst_n, // Asynchronous reset
  hht_if.device port, // Processor port
  input wire hht_mode_t mode, // Terminal operating mode
  input wire logic cfg_wr, // Configuration register write
  input wire logic [HHT_CFG_W-1:0] cfg_wdata, // Configuration write data
  output logic [HHT_CFG_W-1:0] cfg_rdata, // Configuration readback
  input wire logic wait_for_trigger_instr, // Enhanced BC waits for trigger
  output logic status_flag, // Subsystem flag in status word
  output logic bc_start, // BC frame start pulse
  output logic instr_advance, // Enhanced BC resume pulse
  output logic monitor_start, // Word monitor start pulse
  output logic transparent_mode // Latched host mode
);
  // ==========================================================================
  // Parameter checks
  // The down-counter is HHT_CNT_W bits wide, so longer accesses cannot be counted.
  if (ACCESS_CYC < 1 || ACCESS_CYC > (1 << HHT_CNT_W) - 1) begin : g_bad_access
    $error("ACCESS_CYC out of range");
  end
  // The RAM model decodes at most eight address bits.
  if (MEM_WORDS < 1 || MEM_WORDS > 256) begin : g_bad_words
    $error("MEM_WORDS out of range");
  end

  // ==========================================================================
  // State
  typedef enum logic [1:0] {HHT_IDLE, HHT_BUSY, HHT_DONE} hht_dstate_t;
  typedef struct packed {
    logic [1:0] strb_sync;
    logic [1:0] trig_sync;
    logic trig_prev;
    logic [1:0] flag_sync;
    logic strap_taken;
    logic transparent;
    hht_dstate_t st;
    logic [HHT_CNT_W-1:0] cnt;
    logic rd;
    logic mem;
    logic [HHT_ADDR_W-1:0] addr;
    logic [HHT_DATA_W-1:0] wdata;
    logic [HHT_DATA_W-1:0] rdata;
    logic [HHT_CFG_W-1:0] cfg;
    logic [HHT_DATA_W-1:0] reg_file;
    logic status_flag;
    logic bc_start;
    logic advance;
    logic mon_start;
  } hht_dev_t;

  // ==========================================================================
  // Helpers
  // Word index into the RAM model; upper address bits alias onto it.
  function automatic int unsigned mem_index(input logic [HHT_ADDR_W-1:0] a);
    return a % MEM_WORDS;
  endfunction
  // External start is honoured only when software has enabled it.
  function automatic logic ext_start_on(input logic [HHT_CFG_W-1:0] c);
    return c[HHT_CFG_EXTSTART_BIT];
  endfunction

  hht_dev_t s_r, s_nxt;
  logic [HHT_DATA_W-1:0] mem_r [MEM_WORDS];
  logic mem_we;
  logic trig_rise;
  logic strb_low;

  // Strobe and trigger pass two flops before any logic reads them; this adds
  // two cycles of latency to every host cycle and to every trigger event.
  assign strb_low = ~s_r.strb_sync[1];
  assign trig_rise = s_r.trig_sync[1] & ~s_r.trig_prev; // [R16]

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    mem_we = 1'b0;
    s_nxt.strb_sync = {s_r.strb_sync[0], port.host_strobe_n};
    s_nxt.trig_sync = {s_r.trig_sync[0], port.external_trigger_in};
    s_nxt.trig_prev = s_r.trig_sync[1];
    s_nxt.flag_sync = {s_r.flag_sync[0], port.external_trigger_in};
    s_nxt.bc_start = 1'b0;
    s_nxt.advance = 1'b0;
    s_nxt.mon_start = 1'b0;
    if (!s_r.strap_taken) begin
      // Strap caught once after reset release, then held.
      s_nxt.strap_taken = 1'b1;
      s_nxt.transparent = port.host_mode_strap == HHT_STRAP_TRANSPARENT; // [R7]
    end
    if (cfg_wr) begin
      s_nxt.cfg = cfg_wdata; // [R2]
    end
    // The shared pin is a subsystem flag only in RT mode.
    s_nxt.status_flag = (mode == HHT_MODE_RT)
                        & (s_r.cfg[HHT_CFG_FLAG_BIT] | ~s_r.flag_sync[1]); // [R1]
    // Each synchronised rise gives at most one pulse, whatever the mode.
    if (trig_rise) begin
      unique case (mode)
        HHT_MODE_BC: s_nxt.bc_start = ext_start_on(s_r.cfg); // [R3]
        HHT_MODE_EBC: s_nxt.advance = wait_for_trigger_instr; // [R4]
        HHT_MODE_WMON: s_nxt.mon_start = ext_start_on(s_r.cfg); // [R5]
        HHT_MODE_MMON: s_nxt.mon_start = 1'b0; // [R6]
        default: s_nxt.bc_start = 1'b0;
      endcase
    end
    unique case (s_r.st)
      HHT_IDLE: begin
        // Fields are stable by the time the synchronised strobe falls.
        if (strb_low && s_r.strap_taken) begin
          s_nxt.st = HHT_BUSY;
          s_nxt.cnt = HHT_CNT_W'(ACCESS_CYC);
          s_nxt.rd = port.host_rd;
          s_nxt.mem = port.mem_reg_sel == HHT_SEL_MEM;
          s_nxt.addr = port.addr;
          s_nxt.wdata = port.wdata;
        end
      end
      HHT_BUSY: begin
        // The access lands on the last count, before transparent-mode ready answers the host.
        if (s_r.cnt == HHT_CNT_W'(1)) begin
          s_nxt.st = HHT_DONE;
          if (s_r.rd) begin
            s_nxt.rdata = s_r.mem ? mem_r[mem_index(s_r.addr)] : s_r.reg_file; // [R8]
          end else if (s_r.mem) begin
            mem_we = 1'b1; // [R9]
          end else begin
            s_nxt.reg_file = s_r.wdata; // [R9]
          end
        end else begin
          s_nxt.cnt = s_r.cnt - HHT_CNT_W'(1);
        end
      end
      HHT_DONE: begin
        // Both modes wait to see the strobe high, so a strobe still held low
        // from this cycle is never taken as a second access.
        if (!strb_low) begin // [R10]
          s_nxt.st = HHT_IDLE;
        end
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // Synchroniser flops reset to the idle high level of their pins, so that
  // no false trigger edge or strobe follows reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{strb_sync: 2'b11, trig_sync: 2'b11, trig_prev: 1'b1, flag_sync: 2'b11,
               st: HHT_IDLE, cfg: HHT_CFG_RESET, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // The RAM model has no reset: a word reads as unknown until written.
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_r[mem_index(s_r.addr)] <= s_r.wdata;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    if (s_r.transparent) begin
      port.host_ready_n = s_r.st != HHT_DONE; // [R8] [R9]
    end else begin
      // Buffered ready falls only while the internal access runs.
      port.host_ready_n = s_r.st != HHT_BUSY; // [R11] [R12]
    end
  end
  assign port.io_enable_n_out = s_r.st != HHT_BUSY; // [R13]
  assign port.rdata = s_r.rdata;
  assign cfg_rdata = s_r.cfg; // [R2]
  assign status_flag = s_r.status_flag;
  assign bc_start = s_r.bc_start;
  assign instr_advance = s_r.advance;
  assign monitor_start = s_r.mon_start;
  assign transparent_mode = s_r.transparent;
endmodule
`default_nettype wire

// ===== rtl/hht_host.sv
// Host end: turns a plain register port into strobed processor cycles.
// Assumes the device answers through ready and I/O enable on the interface.
`timescale 1ns/10ps
`default_nettype none
module hht_host
  import hht_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic arst_n, // Asynchronous reset
  hht_if.host port, // Processor port
  input wire logic [1:0] reg_addr, // Control register address
  input wire logic [15:0] reg_wdata, // Control write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, one cycle after strobe
  output logic bus_buf_en // External buffer enable
);
  // ==========================================================================
  // Register map: 0 address, 1 write data / read result, 2 command, 3 status.
  localparam logic [1:0] HHT_R_ADDR = 2'h0;
  localparam logic [1:0] HHT_R_DATA = 2'h1;
  localparam logic [1:0] HHT_R_CMD = 2'h2;
  localparam logic [1:0] HHT_R_STAT = 2'h3;
  localparam int HHT_CMD_GO = 0;
  localparam int HHT_CMD_RD = 1;
  localparam int HHT_CMD_MEM = 2;

  typedef enum logic [1:0] {HHT_H_IDLE, HHT_H_WAITLO, HHT_H_WAITHI} hht_hstate_t;
  typedef struct packed {
    logic [1:0] rdy_sync;
    logic [1:0] io_enable_n_out_sync;
    hht_hstate_t st;
    logic [15:0] addr;
    logic [15:0] data;
    logic rd;
    logic mem;
    logic strobe_n;
    logic done;
    logic [15:0] rdata;
  } hht_host_st_t;

  hht_host_st_t s_r, s_nxt;
  logic rdy_lo;
  assign rdy_lo = ~s_r.rdy_sync[1];

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdy_sync = {s_r.rdy_sync[0], port.host_ready_n};
    s_nxt.io_enable_n_out_sync = {s_r.io_enable_n_out_sync[0], port.io_enable_n_out};
    s_nxt.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        HHT_R_ADDR: s_nxt.rdata = s_r.addr;
        HHT_R_DATA: s_nxt.rdata = s_r.data;
        HHT_R_CMD: s_nxt.rdata = {13'h0, s_r.mem, s_r.rd, s_r.st != HHT_H_IDLE};
        HHT_R_STAT: s_nxt.rdata = {14'h0, s_r.done, s_r.st != HHT_H_IDLE};
      endcase
    end
    if (reg_wr && s_r.st == HHT_H_IDLE) begin
      unique case (reg_addr)
        HHT_R_ADDR: s_nxt.addr = reg_wdata;
        HHT_R_DATA: s_nxt.data = reg_wdata;
        HHT_R_CMD: begin
          s_nxt.rd = reg_wdata[HHT_CMD_RD];
          s_nxt.mem = reg_wdata[HHT_CMD_MEM] ? HHT_SEL_MEM : HHT_SEL_REG; // [R15]
          if (reg_wdata[HHT_CMD_GO]) begin
            s_nxt.st = HHT_H_WAITLO;
            s_nxt.strobe_n = 1'b0;
            s_nxt.done = 1'b0;
          end
        end
        HHT_R_STAT: s_nxt.done = 1'b0;
      endcase
    end
    unique case (s_r.st)
      HHT_H_IDLE: ;
      HHT_H_WAITLO: begin
        if (rdy_lo) begin
          s_nxt.strobe_n = 1'b1; // [R10]
          s_nxt.st = HHT_H_WAITHI;
          if (s_r.rd) begin
            s_nxt.data = port.rdata;
          end
        end
      end
      HHT_H_WAITHI: begin
        if (!rdy_lo) begin
          s_nxt.st = HHT_H_IDLE; // [R12]
          s_nxt.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{rdy_sync: 2'b11, io_enable_n_out_sync: 2'b11, st: HHT_H_IDLE, strobe_n: 1'b1,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign port.host_strobe_n = s_r.strobe_n;
  assign port.host_rd = s_r.rd;
  assign port.mem_reg_sel = s_r.mem;
  assign port.addr = s_r.addr;
  assign port.wdata = s_r.data;
  assign reg_rdata = s_r.rdata;
  assign bus_buf_en = ~s_r.io_enable_n_out_sync[1]; // [R14]
endmodule
`default_nettype wire

// ===== testbench/hht_properties.sv
// Handshake checker for the processor port between the host and terminal ends.
// Assumes one clock, an active-low asynchronous reset and the interface signals.
`timescale 1ns/10ps
`default_nettype none
module hht_properties
  import hht_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic host_strobe_n, // Transfer strobe
  input wire logic host_ready_n, // Ready handshake
  input wire logic io_enable_n_out, // Internal access marker
  input wire logic host_mode_strap // Host mode strap
);
  logic tp;
  assign tp = host_mode_strap == HHT_STRAP_TRANSPARENT;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // Access sequences
  // The busy span assumes the default access length of two cycles.
  sequence s_busy;
    !io_enable_n_out [*2] ##1 io_enable_n_out;
  endsequence
  sequence s_answer;
    host_ready_n [*3] ##[1:6] !host_ready_n;
  endsequence
  // ==========================================================================
  // Properties
  property p_busy_len;
    $fell(io_enable_n_out) |-> s_busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("access span wrong");
  property p_busy_cause;
    $fell(io_enable_n_out) |-> $past(!host_strobe_n, 2);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("access without strobe");
  property p_answer;
    tp && $fell(host_strobe_n) |-> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("ready timing wrong");
  property p_no_early;
    tp && !io_enable_n_out |-> host_ready_n;
  endproperty
  a_no_early: assert property (p_no_early) else $error("ready before data");
  property p_done;
    tp && $rose(io_enable_n_out) |-> !host_ready_n;
  endproperty
  a_done: assert property (p_done) else $error("ready late after access");
  property p_release;
    tp && $rose(host_strobe_n) |-> ##[1:5] host_ready_n;
  endproperty
  a_release: assert property (p_release) else $error("ready not released");
  property p_hold;
    tp && !host_strobe_n && host_ready_n |=> !host_strobe_n;
  endproperty
  a_hold: assert property (p_hold) else $error("strobe dropped early");
  property p_buffered;
    !tp |-> host_ready_n == io_enable_n_out;
  endproperty
  a_buffered: assert property (p_buffered) else $error("buffered ready wrong");
endmodule
`default_nettype wire

// ===== testbench/host_handshake_and_trigger_test.sv
// Testbench joining host and terminal ends through the processor port.
// Assumes the host register map: 0 address, 1 data, 2 command, 3 status.
`timescale 1ns/10ps
`default_nettype none
module host_handshake_and_trigger_test;
  import hht_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  hht_mode_t mode = HHT_MODE_RT;
  logic cfg_wr = 1'b0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic wait_for_trigger_instr = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] cfg_rdata;
  logic [15:0] reg_rdata;
  logic status_flag, bc_start, instr_advance, monitor_start, transparent_mode, bus_buf_en;
  int n_fail = 0;
  int checks_done = 0;
  int n_bc = 0, n_adv = 0, n_mon = 0, n_buf = 0;
  int seed = 32'h2a77;
  int b1, b2, b3, i, m, k;
  logic [15:0] a, d, q, cw;
  hht_if bus (.clk(clk));
  hht_device hht_device_i (.clk(clk), .arst_n(arst_n), .port(bus), .mode(mode),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .wait_for_trigger_instr(wait_for_trigger_instr), .status_flag(status_flag),
    .bc_start(bc_start), .instr_advance(instr_advance), .monitor_start(monitor_start),
    .transparent_mode(transparent_mode));
  hht_host hht_host_i (.clk(clk), .arst_n(arst_n), .port(bus), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_buf_en(bus_buf_en));
  hht_properties hht_properties_i (.clk(clk), .arst_n(arst_n),
    .host_strobe_n(bus.host_strobe_n), .host_ready_n(bus.host_ready_n),
    .io_enable_n_out(bus.io_enable_n_out), .host_mode_strap(bus.host_mode_strap));
  initial forever #25 clk = ~clk;
  // ==========================================================================
  // Event counters
  always @(posedge clk) begin
    if (bc_start === 1'b1) n_bc <= n_bc + 1;
    if (instr_advance === 1'b1) n_adv <= n_adv + 1;
    if (monitor_start === 1'b1) n_mon <= n_mon + 1;
    if (bus_buf_en === 1'b1) n_buf <= n_buf + 1;
  end
  // ==========================================================================
  // Tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wr(input logic [1:0] ad, input logic [15:0] dt);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [1:0] ad, output logic [15:0] dt);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 dt = reg_rdata;
  endtask
  // Polling is bounded so a lost handshake shows as a mismatch, not a hang.
  task host_op(input logic sel, input logic rdop, input logic [15:0] ad,
      input logic [15:0] dt, output logic [15:0] res);
    logic [15:0] st;
    int n;
    st = 16'h0000;
    wr(2'h0, ad);
    wr(2'h1, dt);
    wr(2'h2, {13'h0, sel, rdop, 1'b1});
    for (n = 0; n < 40 && st[1] !== 1'b1; n++) rd(2'h3, st);
    chk(16'(st[1]), 16'h0001);
    wr(2'h3, 16'h0000);
    rd(2'h1, res);
  endtask
  task do_reset(input logic strap);
    @(posedge clk);
    arst_n <= 1'b0;
    bus.host_mode_strap <= strap;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(16'(transparent_mode), 16'(strap));
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    bus.host_mode_strap = HHT_STRAP_TRANSPARENT;
    bus.external_trigger_in = 1'b1;
    for (m = 0; m < 2; m++) begin
      do_reset(m == 0);
      for (i = 0; i < 4; i++) begin
        a = (i == 0) ? 16'h000f : 16'($random(seed)) & 16'h000f;
        d = 16'($random(seed));
        b1 = n_buf;
        host_op(HHT_SEL_MEM, 1'b0, a, d, q);
        host_op(HHT_SEL_MEM, 1'b1, a, 16'h0000, q);
        chk(q, d);
        if (m == 0) chk(16'(n_buf > b1), 16'h0001);
      end
      d = ~d;
      host_op(HHT_SEL_REG, 1'b0, 16'h0000, d, q);
      host_op(HHT_SEL_REG, 1'b1, 16'h0000, 16'h0000, q);
      chk(q, d);
    end
    for (m = 0; m < 5; m++) begin
      for (k = 0; k < 4; k++) begin
        @(posedge clk);
        mode <= hht_mode_t'(m);
        wait_for_trigger_instr <= k[1];
        cw = (16'($random(seed)) & 16'hfe7f) | 16'(k << 7);
        cfg_wdata <= cw;
        cfg_wr <= 1'b1;
        bus.external_trigger_in <= 1'b0;
        @(posedge clk);
        cfg_wr <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk(cfg_rdata, cw);
        chk(16'(status_flag), 16'(mode == HHT_MODE_RT));
        b1 = n_bc;
        b2 = n_adv;
        b3 = n_mon;
        @(posedge clk);
        bus.external_trigger_in <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk(16'(status_flag), 16'(mode == HHT_MODE_RT && k[1]));
        chk(16'(n_bc - b1), 16'(mode == HHT_MODE_BC && k[0]));
        chk(16'(n_adv - b2), 16'(mode == HHT_MODE_EBC && k[1]));
        chk(16'(n_mon - b3), 16'(mode == HHT_MODE_WMON && k[0]));
      end
    end
    report_and_stop;
  end
  initial begin
    #1000000;
    n_fail++;
    report_and_stop;
  end
endmodule
`default_nettype wire
